//--- hw/fswc_pkg.sv
package fswc_pkg;
   // Internal display clocks per line; one design clock stands for one of them
   localparam int unsigned LINE_CLKS = 23;
   localparam logic [4:0] LINE_LAST = 5'(LINE_CLKS - 1);
   // Field widths
   localparam int NL_W = 6;
   localparam int PORCH_W = 4;
   localparam int FMP_W = 9;
   localparam int FMI_W = 3;
   localparam int LINE_W = 10;
   localparam int ROW_W = 9;
   localparam int DATA_W = 18;
   // Display lines are (count + 1) * 8
   localparam int NL_SHIFT = 3;
   localparam logic [LINE_W-1:0] LINE_ONE = 10'h001;
   // Display mode codes
   localparam logic [1:0] MODE_INT = 2'h0;
   localparam logic [1:0] MODE_VSYNC = 2'h2;
   // Highest legal frame-mark position
   localparam logic [FMP_W-1:0] FMP_LAST = 9'h1BF;
   // Frame-mark interval codes and periods
   localparam logic [FMI_W-1:0] FMI_EVERY1 = 3'h0;
   localparam logic [FMI_W-1:0] FMI_EVERY2 = 3'h1;
   localparam logic [FMI_W-1:0] FMI_EVERY4 = 3'h3;
   localparam logic [FMI_W-1:0] FMI_EVERY6 = 3'h5;
   localparam logic [2:0] PER_NONE = 3'h0;
   localparam logic [2:0] PER_1 = 3'h1;
   localparam logic [2:0] PER_2 = 3'h2;
   localparam logic [2:0] PER_4 = 3'h4;
   localparam logic [2:0] PER_6 = 3'h6;
   // Least distance between written row and displayed row
   localparam logic [ROW_W-1:0] SAFE_LINES = 9'h002;
   // Vertical sync low time issued by the host, one line
   localparam logic [4:0] VSYNC_LOW_CLKS = 5'(LINE_CLKS);
   // Host register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_FMCFG = 8'h04;
   localparam logic [7:0] REG_TIMING = 8'h08;
   localparam logic [7:0] REG_VSYNC = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_WLINE = 8'h14;
   localparam logic [7:0] REG_WDATA = 8'h18;
   // Field positions
   localparam int CTRL_MODE = 0;
   localparam int CTRL_RAMP = 2;
   localparam int CTRL_AID = 3;
   localparam int CTRL_FWM = 4;
   localparam int CTRL_PART = 5;
   localparam int CTRL_SCRL = 6;
   localparam int CTRL_FMSYNC = 7;
   localparam int FMCFG_FMI = 16;
   localparam int TIM_BP = 8;
   localparam int TIM_FP = 12;
   localparam int STAT_FM = 0;
   localparam int STAT_DACT = 1;
   localparam int STAT_VSB = 2;
   localparam int STAT_ROW = 16;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h10;
   localparam logic [NL_W-1:0] NL_RST = 6'h35;
   localparam logic [PORCH_W-1:0] BP_RST = 4'hE;
   localparam logic [PORCH_W-1:0] FP_RST = 4'h2;
   localparam logic [FMP_W-1:0] FMP_RST = 9'h000;
   localparam logic [FMI_W-1:0] FMI_RST = 3'h0;

   // Frame phase within one refresh
   typedef enum logic [1:0] {FSWC_BACK, FSWC_DISP, FSWC_FRONT} fswc_phase_t;

   // Interval code to frame period, zero for disallowed codes
   function automatic logic [2:0] fmi_period(input logic [FMI_W-1:0] code);
      case (code)
         FMI_EVERY1: fmi_period = PER_1;
         FMI_EVERY2: fmi_period = PER_2;
         FMI_EVERY4: fmi_period = PER_4;
         FMI_EVERY6: fmi_period = PER_6;
         default: fmi_period = PER_NONE;
      endcase
   endfunction : fmi_period
endpackage : fswc_pkg

//--- hw/fswc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fswc_link_if;
   logic [1:0] display_mode_select;
   logic ram_access_path_select;
   logic address_increment_direction;
   logic fast_write_mode;
   logic [fswc_pkg::FMP_W-1:0] frame_mark_line_position;
   logic [fswc_pkg::FMI_W-1:0] frame_mark_interval;
   logic [fswc_pkg::NL_W-1:0] display_line_count;
   logic [fswc_pkg::PORCH_W-1:0] back_porch_lines;
   logic [fswc_pkg::PORCH_W-1:0] front_porch_lines;
   logic partial_req;
   logic scroll_req;
   logic vsync_n;
   logic wr_stb;
   logic [fswc_pkg::ROW_W-1:0] wr_line;
   logic [fswc_pkg::DATA_W-1:0] wr_data;
   logic frame_mark_output;
   logic disp_active;
   logic [fswc_pkg::ROW_W-1:0] disp_row;

   // Panel controller end
   modport dev (
      input display_mode_select, ram_access_path_select, address_increment_direction,
      input fast_write_mode, frame_mark_line_position, frame_mark_interval,
      input display_line_count, back_porch_lines, front_porch_lines,
      input partial_req, scroll_req, vsync_n, wr_stb, wr_line, wr_data,
      output frame_mark_output, disp_active, disp_row
   );
   // Host end
   modport host (
      output display_mode_select, ram_access_path_select, address_increment_direction,
      output fast_write_mode, frame_mark_line_position, frame_mark_interval,
      output display_line_count, back_porch_lines, front_porch_lines,
      output partial_req, scroll_req, vsync_n, wr_stb, wr_line, wr_data,
      input frame_mark_output, disp_active, disp_row
   );
endinterface : fswc_link_if
`default_nettype wire

//--- hw/fswc_line_timer.sv
`timescale 1ns/10ps
`default_nettype none
module fswc_line_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   output logic line_end_o,
   output logic [fswc_pkg::LINE_W-1:0] line_idx_o
);
   logic [4:0] clk_cnt_q; // Clocks into the current line
   logic [fswc_pkg::LINE_W-1:0] line_q; // Line index within the frame

   // Last clock of a line
   assign line_end_o = (clk_cnt_q == fswc_pkg::LINE_LAST);
   assign line_idx_o = line_q;

   // Clock count within a line; restart realigns the line grid
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i || line_end_o) begin
         clk_cnt_q <= 5'h00;
      end else begin
         clk_cnt_q <= clk_cnt_q + 5'h01;
      end
   end

   // Line count saturates so a missing sync cannot wrap into the display
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         line_q <= '0;
      end else if (line_end_o && (line_q != '1)) begin
         line_q <= line_q + fswc_pkg::LINE_ONE;
      end
   end
endmodule : fswc_line_timer
`default_nettype wire

//--- hw/fswc_device.sv
// Notes on behaviour
// R1: host picks sync mode: mode 10, path 0
// R2: mode change applies at next frame start
// R3: no partial or scroll in sync mode
// R4: host sets increment direction 0 in sync mode
// R5: host uses fast write in both modes
// R6: sync front porch lasts until next sync
// R7: host oscillator setting keeps seven percent margin
// R8: host writes stay two lines ahead
// R9: host counts delay after sync fall; fswc_host counts none and gates pixel writes on row distance, and also on the mark flag when CTRL_FMSYNC is set
// R10: frame mark on the selected line
// R11: positions 0 to 1BF; higher disallowed
// R12: interval codes give 1, 2, 4, 6 frames
// R13: host starts writes at mark rising edge
// R14: mark high one line, else low
`timescale 1ns/10ps
`default_nettype none
module fswc_device (
   input wire logic clk_i,
   input wire logic rst_i,
   fswc_link_if.dev link,
   output logic frame_start_o,
   output logic sync_mode_o,
   output logic partial_active_o,
   output logic scroll_active_o,
   output logic ram_wr_o,
   output logic [fswc_pkg::ROW_W-1:0] ram_line_o,
   output logic [fswc_pkg::DATA_W-1:0] ram_data_o
);
   localparam int LW = fswc_pkg::LINE_W;

   logic line_end; // Last clock of a line
   logic [LW-1:0] line_idx; // Line index from frame start
   logic [LW-1:0] next_idx; // Index of the line about to begin
   logic [LW-1:0] nl_lines; // Display lines of the frame
   logic [LW-1:0] bp_lines; // Back porch widened
   logic [LW-1:0] fp_lines; // Front porch widened
   logic [LW-1:0] disp_end; // First front porch line
   logic [LW-1:0] frame_last; // Last line of an internal frame
   logic sync_req; // Host asks for sync-locked operation
   logic sync_mode_q; // Mode in force for this frame
   logic vsync_prev_q; // Sync level one clock ago
   logic vsync_fall; // Falling edge of the sync input
   logic internal_end; // Internal timing reached frame end
   logic frame_start; // New frame begins this clock
   fswc_pkg::fswc_phase_t phase_q; // Current frame phase
   logic [2:0] period; // Mark interval in frames
   logic [2:0] fm_cnt_q; // Frames since last marked frame
   logic fm_qual_q; // This frame carries a mark
   logic fm_qual_new; // Qualifier for the frame now starting
   logic fmp_legal; // Position is within the legal range
   logic fm_q; // Frame-mark output register
   logic [LW-1:0] fmp_wide; // Position widened to line index
   logic [LW-1:0] row_wide; // Display row before narrowing
   logic disp_active_q; // Display phase flag to the host
   logic [fswc_pkg::ROW_W-1:0] disp_row_q; // Displayed row to the host

   // Line grid; restarted at every frame start
   fswc_line_timer fswc_line_timer_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(frame_start),
      .line_end_o(line_end),
      .line_idx_o(line_idx)
   );

   // Frame geometry from the host's timing fields
   always_comb begin
      nl_lines = LW'(({4'h0, link.display_line_count} + fswc_pkg::LINE_ONE)
                     << fswc_pkg::NL_SHIFT);
      bp_lines = {6'h00, link.back_porch_lines};
      fp_lines = {6'h00, link.front_porch_lines};
      disp_end = bp_lines + nl_lines;
      frame_last = disp_end + fp_lines - fswc_pkg::LINE_ONE;
      next_idx = line_idx + fswc_pkg::LINE_ONE;
   end

   // R1: sync mode needs mode 10 and system path
   assign sync_req = (link.display_mode_select == fswc_pkg::MODE_VSYNC)
                     && !link.ram_access_path_select;

   // Sync edge detect; input is already synchronous to clk_i
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vsync_prev_q <= 1'b1;
      end else begin
         vsync_prev_q <= link.vsync_n;
      end
   end
   assign vsync_fall = vsync_prev_q && !link.vsync_n;

   // End of an internally timed frame; at or past the last line, so a frame
   // shortened by a timing write in mid-frame still ends
   assign internal_end = line_end && (line_idx >= frame_last);

   // R6: in sync mode only the sync fall ends the front porch
   // A pending return to internal mode may also end it on internal timing,
   // so a host that stops sync after leaving the mode cannot stall the panel
   always_comb begin
      if (sync_mode_q) begin
         frame_start = vsync_fall || (!sync_req && internal_end);
      end else begin
         frame_start = internal_end;
      end
   end
   assign frame_start_o = frame_start;

   // R2: mode request sampled only at a frame boundary
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_mode_q <= 1'b0;
      end else if (frame_start) begin
         sync_mode_q <= sync_req;
      end
   end
   assign sync_mode_o = sync_mode_q;

   // R3: partial display and scroll blocked in sync mode
   assign partial_active_o = link.partial_req && !sync_mode_q;
   assign scroll_active_o = link.scroll_req && !sync_mode_q;

   // Frame phase sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= fswc_pkg::FSWC_BACK;
      end else if (frame_start) begin
         // Zero back porch goes straight to display
         phase_q <= (bp_lines == '0) ? fswc_pkg::FSWC_DISP : fswc_pkg::FSWC_BACK;
      end else if (line_end) begin
         case (phase_q)
            fswc_pkg::FSWC_BACK: begin
               if (next_idx >= bp_lines) begin
                  phase_q <= fswc_pkg::FSWC_DISP;
               end
            end
            fswc_pkg::FSWC_DISP: begin
               if (next_idx >= disp_end) begin
                  phase_q <= fswc_pkg::FSWC_FRONT;
               end
            end
            // R6: front porch holds until the frame restarts
            fswc_pkg::FSWC_FRONT: begin
               phase_q <= fswc_pkg::FSWC_FRONT;
            end
            default: begin
               phase_q <= fswc_pkg::FSWC_BACK;
            end
         endcase
      end
   end

   // Displayed row report, registered for the host's distance check
   assign row_wide = line_idx - bp_lines;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disp_active_q <= 1'b0;
         disp_row_q <= '0;
      end else begin
         disp_active_q <= (phase_q == fswc_pkg::FSWC_DISP);
         disp_row_q <= row_wide[fswc_pkg::ROW_W-1:0];
      end
   end
   assign link.disp_active = disp_active_q;
   assign link.disp_row = disp_row_q;

   // R12: interval decode; a frame that starts under a disallowed code gets no mark
   assign period = fswc_pkg::fmi_period(link.frame_mark_interval);
   assign fm_qual_new = (fm_cnt_q == 3'h0) && (period != fswc_pkg::PER_NONE);

   // R12: frame counter picks every n-th frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fm_cnt_q <= 3'h0;
         fm_qual_q <= 1'b0;
      end else if (frame_start) begin
         fm_qual_q <= fm_qual_new;
         if (fm_cnt_q >= period - 3'h1) begin
            fm_cnt_q <= 3'h0;
         end else begin
            fm_cnt_q <= fm_cnt_q + 3'h1;
         end
      end
   end

   // R11: positions above the last legal line never fire
   assign fmp_legal = (link.frame_mark_line_position <= fswc_pkg::FMP_LAST);
   assign fmp_wide = {1'b0, link.frame_mark_line_position};

   // R10: mark raised as the selected line begins
   // R14: held for exactly that line, low otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fm_q <= 1'b0;
      end else if (frame_start) begin
         fm_q <= fm_qual_new && fmp_legal && (fmp_wide == '0);
      end else if (line_end) begin
         // A saturated line count wraps next_idx to zero; never mark there
         fm_q <= fm_qual_q && fmp_legal && (fmp_wide == next_idx) && (line_idx != '1);
      end
   end
   assign link.frame_mark_output = fm_q;

   // Host RAM writes passed on from flip-flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ram_wr_o <= 1'b0;
         ram_line_o <= '0;
         ram_data_o <= '0;
      end else begin
         ram_wr_o <= link.wr_stb;
         if (link.wr_stb) begin
            ram_line_o <= link.wr_line;
            ram_data_o <= link.wr_data;
         end
      end
   end
endmodule : fswc_device
`default_nettype wire

//--- hw/fswc_host.sv
`timescale 1ns/10ps
`default_nettype none
module fswc_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   fswc_link_if.host link
);
   logic [7:0] ctrl_q; // Mode and option bits
   logic [31:0] fmcfg_q; // Mark position and interval
   logic [31:0] timing_q; // Line count and porches
   logic [fswc_pkg::ROW_W-1:0] wline_q; // Row of the next pixel write
   logic [4:0] vs_cnt_q; // Remaining sync low clocks
   logic vsync_n_q; // Sync output register
   logic fm_prev_q; // Mark level one clock ago
   logic fm_seen_q; // Sticky mark-rise flag
   logic wr_stb_q; // Pixel write strobe
   logic [fswc_pkg::ROW_W-1:0] wr_line_q; // Pixel write row
   logic [fswc_pkg::DATA_W-1:0] wr_data_q; // Pixel write data
   logic ack_q; // Bus acknowledge
   logic [31:0] rdata_q; // Read data register
   logic req; // New bus request
   logic wr_ok; // Pixel write may proceed
   logic line_safe; // Written row clear of display
   logic [fswc_pkg::ROW_W-1:0] ahead; // Rows written ahead of display
   logic sync_sel; // Host runs sync-locked mode
   logic wr_acc; // Accepted bus write
   logic fm_clr; // Software clears the mark flag
   logic [31:0] rmux; // Read selection
   logic [31:0] wline_mrg; // Write row after byte-lane merge

   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   // Merged row word; a function result cannot be part-selected directly
   assign wline_mrg = merge({23'h0, wline_q}, wb_dat_i, wb_sel_i);

   // R1: sync mode is mode 10 with system path
   assign sync_sel = (ctrl_q[fswc_pkg::CTRL_MODE +: 2] == fswc_pkg::MODE_VSYNC)
                     && !ctrl_q[fswc_pkg::CTRL_RAMP];

   // R8: written row must lead the displayed row by two
   assign ahead = wline_q - link.disp_row;
   assign line_safe = !link.disp_active || (ahead >= fswc_pkg::SAFE_LINES);
   // R13: mark-synced writes wait for the mark rise
   assign wr_ok = line_safe && (!ctrl_q[fswc_pkg::CTRL_FMSYNC] || fm_seen_q);

   // Pixel writes stall the bus until safe; all else answers next clock
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_acc = req && wb_we_i && ((wb_adr_i != fswc_pkg::REG_WDATA) || wr_ok);
   assign fm_clr = wr_acc && (wb_adr_i == fswc_pkg::REG_STATUS)
                   && wb_sel_i[0] && wb_dat_i[fswc_pkg::STAT_FM];

   // Bus acknowledge, one clock long
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && ((wb_adr_i != fswc_pkg::REG_WDATA) || !wb_we_i || wr_ok);
      end
   end
   assign wb_ack_o = ack_q;

   // Register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= fswc_pkg::CTRL_RST;
         fmcfg_q <= '0;
         timing_q <= '0;
         wline_q <= '0;
         fmcfg_q[fswc_pkg::FMCFG_FMI +: fswc_pkg::FMI_W] <= fswc_pkg::FMI_RST;
         fmcfg_q[0 +: fswc_pkg::FMP_W] <= fswc_pkg::FMP_RST;
         timing_q[0 +: fswc_pkg::NL_W] <= fswc_pkg::NL_RST;
         timing_q[fswc_pkg::TIM_BP +: fswc_pkg::PORCH_W] <= fswc_pkg::BP_RST;
         timing_q[fswc_pkg::TIM_FP +: fswc_pkg::PORCH_W] <= fswc_pkg::FP_RST;
      end else if (wr_acc) begin
         case (wb_adr_i)
            fswc_pkg::REG_CTRL: ctrl_q <= wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_q;
            fswc_pkg::REG_FMCFG: fmcfg_q <= merge(fmcfg_q, wb_dat_i, wb_sel_i);
            fswc_pkg::REG_TIMING: timing_q <= merge(timing_q, wb_dat_i, wb_sel_i);
            fswc_pkg::REG_WLINE: wline_q <= wline_mrg[fswc_pkg::ROW_W-1:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Sync pulse: a write to the sync register drives one line low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vs_cnt_q <= 5'h00;
         vsync_n_q <= 1'b1;
      end else if (wr_acc && (wb_adr_i == fswc_pkg::REG_VSYNC)) begin
         vs_cnt_q <= fswc_pkg::VSYNC_LOW_CLKS;
         vsync_n_q <= 1'b0;
      end else if (vs_cnt_q != 5'h00) begin
         vs_cnt_q <= vs_cnt_q - 5'h01;
         vsync_n_q <= (vs_cnt_q == 5'h01);
      end
   end

   // Mark rise flag; a rise in the clearing clock wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fm_prev_q <= 1'b0;
         fm_seen_q <= 1'b0;
      end else begin
         fm_prev_q <= link.frame_mark_output;
         fm_seen_q <= (link.frame_mark_output && !fm_prev_q) || (fm_seen_q && !fm_clr);
      end
   end

   // Pixel write issue on the accepting clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_stb_q <= 1'b0;
         wr_line_q <= '0;
         wr_data_q <= '0;
      end else begin
         wr_stb_q <= wr_acc && (wb_adr_i == fswc_pkg::REG_WDATA);
         if (wr_acc && (wb_adr_i == fswc_pkg::REG_WDATA)) begin
            wr_line_q <= wline_q;
            wr_data_q <= wb_dat_i[fswc_pkg::DATA_W-1:0];
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rmux = '0;
      case (wb_adr_i)
         fswc_pkg::REG_CTRL: rmux = {24'h0, ctrl_q};
         fswc_pkg::REG_FMCFG: rmux = fmcfg_q;
         fswc_pkg::REG_TIMING: rmux = timing_q;
         fswc_pkg::REG_WLINE: rmux = {23'h0, wline_q};
         fswc_pkg::REG_STATUS: begin
            rmux[fswc_pkg::STAT_FM] = fm_seen_q;
            rmux[fswc_pkg::STAT_DACT] = link.disp_active;
            rmux[fswc_pkg::STAT_VSB] = !vsync_n_q;
            rmux[fswc_pkg::STAT_ROW +: fswc_pkg::ROW_W] = link.disp_row;
         end
         default: rmux = '0;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= '0;
      end else if (req) begin
         rdata_q <= rmux;
      end
   end
   assign wb_dat_o = rdata_q;

   // Link fields
   assign link.display_mode_select = ctrl_q[fswc_pkg::CTRL_MODE +: 2];
   assign link.ram_access_path_select = ctrl_q[fswc_pkg::CTRL_RAMP];
   // R4: increment direction forced to 0 in sync mode
   assign link.address_increment_direction = ctrl_q[fswc_pkg::CTRL_AID] && !sync_sel;
   // R5: fast write forced on in both synced modes
   assign link.fast_write_mode = ctrl_q[fswc_pkg::CTRL_FWM] || sync_sel
                                 || ctrl_q[fswc_pkg::CTRL_FMSYNC];
   assign link.partial_req = ctrl_q[fswc_pkg::CTRL_PART];
   assign link.scroll_req = ctrl_q[fswc_pkg::CTRL_SCRL];
   assign link.frame_mark_line_position = fmcfg_q[0 +: fswc_pkg::FMP_W];
   assign link.frame_mark_interval = fmcfg_q[fswc_pkg::FMCFG_FMI +: fswc_pkg::FMI_W];
   assign link.display_line_count = timing_q[0 +: fswc_pkg::NL_W];
   assign link.back_porch_lines = timing_q[fswc_pkg::TIM_BP +: fswc_pkg::PORCH_W];
   assign link.front_porch_lines = timing_q[fswc_pkg::TIM_FP +: fswc_pkg::PORCH_W];
   assign link.vsync_n = vsync_n_q;
   assign link.wr_stb = wr_stb_q;
   assign link.wr_line = wr_line_q;
   assign link.wr_data = wr_data_q;
endmodule : fswc_host
`default_nettype wire

//--- dv/fswc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module fswc_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] display_mode_select,
   input wire logic ram_access_path_select,
   input wire logic address_increment_direction,
   input wire logic fast_write_mode,
   input wire logic [8:0] frame_mark_line_position,
   input wire logic [2:0] frame_mark_interval,
   input wire logic vsync_n,
   input wire logic wr_stb,
   input wire logic frame_mark_output
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Short aliases keep the properties on one line
   wire fm = frame_mark_output;
   wire sync_req = display_mode_select == 2'h2;
   wire vs_on = sync_req && !ram_access_path_select;
   wire fm_zero = (frame_mark_line_position == 9'h000) && (frame_mark_interval == 3'h0);
   // Settings that may never produce a mark
   wire pos_bad = frame_mark_line_position > 9'h1BF;
   wire code_bad = frame_mark_interval inside {3'h2, 3'h4, 3'h6, 3'h7};
   mark_width_a: assert property ($rose(fm) |-> ##22 fm ##1 !fm)
      else $error("mark width wrong");
   incdir_a: assert property (vs_on |-> !address_increment_direction)
      else $error("increment direction set in sync mode");
   fastwr_a: assert property (vs_on |-> fast_write_mode)
      else $error("fast write off in sync mode");
   // disallowed position; the past term skips a mark launched before the change
   bad_pos_a: assert property (pos_bad && $past(pos_bad) |-> !$rose(fm))
      else $error("mark at disallowed position");
   bad_code_a: assert property (code_bad && $past(code_bad) |-> !$rose(fm))
      else $error("mark with disallowed interval");
   // sync fall starts a frame; the bench pulses sync only once the mode is in force
   sync_start_a: assert property ($fell(vsync_n) && vs_on && fm_zero |-> ##[1:2] $rose(fm))
      else $error("no mark after sync fall");
   // Sync pulse lasts one line
   vsync_low_a: assert property ($fell(vsync_n) |-> ##22 !vsync_n ##1 vsync_n)
      else $error("sync pulse width wrong");
   // One pixel per strobe
   stb_pulse_a: assert property (wr_stb |=> !wr_stb)
      else $error("write strobe longer than one clock");
   cover property ($rose(fm));
   cover property ($fell(vsync_n) && sync_req);
   cover property (wr_stb);
endmodule : fswc_monitor
`default_nettype wire

//--- dv/frame_sync_write_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module frame_sync_write_control_tb;
   logic clk_i, rst_i, cyc, stb, we, ack, fs, sm, pa, sa, rw, fm_q;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dw, dr, rd;
   logic [8:0] rl;
   logic [17:0] rdat;
   int err_total, samples_checked, rises, base, n, starts, sbase;
   // Mark settings and marks expected in twelve frames
   logic [31:0] cfg [7] = '{32'h5, 32'h0, 32'h10000, 32'h30000, 32'h50000, 32'h20000, 32'h1C0};
   int want [7] = '{12, 12, 6, 3, 2, 0, 0};
   fswc_link_if lk ();
   fswc_host fswc_host_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .link(lk));
   fswc_device fswc_device_i (.clk_i, .rst_i, .link(lk), .frame_start_o(fs), .sync_mode_o(sm),
      .partial_active_o(pa), .scroll_active_o(sa), .ram_wr_o(rw), .ram_line_o(rl),
      .ram_data_o(rdat));
   fswc_monitor fswc_monitor_i (.clk_i, .rst_i, .display_mode_select(lk.display_mode_select),
      .ram_access_path_select(lk.ram_access_path_select), .vsync_n(lk.vsync_n),
      .address_increment_direction(lk.address_increment_direction),
      .fast_write_mode(lk.fast_write_mode), .frame_mark_interval(lk.frame_mark_interval),
      .frame_mark_line_position(lk.frame_mark_line_position), .wr_stb(lk.wr_stb),
      .frame_mark_output(lk.frame_mark_output));
   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Count mark rising edges
   always @(posedge clk_i) begin
      fm_q <= lk.frame_mark_output;
      if (lk.frame_mark_output && !fm_q) rises <= rises + 1;
      if (fs) starts <= starts + 1;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Classic single cycle; the slave may stall a pixel write, so the wait is bounded
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      for (n = 0; n < 3000 && ack !== 1'b1; n++) @(posedge clk_i);
      if (n == 3000) begin
         err_total++;
         print_verdict();
      end
      rd = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task print_verdict;
      $display("errors %0d compares %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // Wait for a mark rise, bounded
   task wait_mark;
      for (n = 0; n < 300 && !(lk.frame_mark_output && !fm_q); n++) @(posedge clk_i);
      chk(n < 300, 1);
   endtask : wait_mark
   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, adr, dw} = '0;
      sel = 4'hF;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, 8'h00, 0);
      chk(rd, 32'h10);
      wb(0, 8'h08, 0);
      chk(rd, 32'h2E35);
      wb(0, 8'h20, 0);
      chk(rd, 0);
      // Ten-line frame of 230 clocks keeps the run short
      wb(1, 8'h08, 32'h1100);
      for (int i = 0; i < 7; i++) begin
         wb(1, 8'h04, cfg[i]);
         repeat (2760) @(posedge clk_i);
         base = rises;
         repeat (2760) @(posedge clk_i);
         chk(rises - base, want[i]);
      end
      wb(1, 8'h04, 0);
      wb(1, 8'h00, 32'h70);
      chk(pa & sa, 1);
      // Ask for sync mode right after a frame start
      wait_mark();
      wb(1, 8'h00, 32'h7A);
      chk(sm, 0);
      repeat (250) @(posedge clk_i);
      chk({sm, pa, sa}, 3'h4);
      base = rises;
      sbase = starts;
      // sync comes well after the 230-clock frame has ended
      repeat (600) @(posedge clk_i);
      chk(rises - base, 0);
      chk(starts - sbase, 0);
      wb(1, 8'h0C, 0);
      repeat (60) @(posedge clk_i);
      chk(rises - base, 1);
      chk(starts - sbase, 1);
      wb(1, 8'h00, 32'h10);
      chk(sm, 1);
      // pixel writes start late after the sync fall; row 2 sits near the display
      wb(1, 8'h14, 32'h2);
      wb(1, 8'h18, 32'h2ABCD);
      for (n = 0; n < 60 && rw !== 1'b1; n++) @(posedge clk_i);
      chk(rw, 1);
      chk({rl, rdat}, {9'h002, 18'h2ABCD});
      chk(lk.disp_active && (9'(rl - lk.disp_row) < 9'h002), 0);
      // Mark-synced writes stall until the next mark rise
      wb(1, 8'h00, 32'h90);
      wait_mark();
      wb(1, 8'h10, 32'h1);
      base = rises;
      wb(1, 8'h18, 32'h3);
      chk(rises != base, 1);
      print_verdict();
   end
endmodule : frame_sync_write_control_tb
`default_nettype wire
